// [hdl/samc_pkg.sv]
/*
 * Shared constants for the spindle and actuator mode control block.
 * Assumes a 50 MHz system clock; the serial port runs on its own clock.
 */
package samc_pkg;
	localparam int WORD_W = 24;
	localparam logic [23:0] WORD_RESET = 24'h00_0000;
	localparam int BIT_SPINDLE_OFF = 23;
	localparam int BIT_ACTUATOR_OFF = 22;
	localparam int BIT_PARK = 21;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SUPPLY_FAULT_NS = 1000;
	// A drop must last more than the limit, so the count rounds up.
	localparam int SUPPLY_FAULT_CYC = (SUPPLY_FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BRAKE_DELAY_CYC = 1000;
	localparam logic [2:0] PHASE_STEP0 = 3'h1;
	// Phase drive codes: float, low, high.
	typedef enum logic [1:0] {SAMC_FLOAT, SAMC_LOW, SAMC_HIGH} samc_drive_t;
	// Failure sequencing states.
	typedef enum {SAMC_RUN, SAMC_FAIL_FLOAT, SAMC_FAIL_BRAKE} samc_fail_t;
endpackage : samc_pkg

// [hdl/samc_mode_ctrl.sv]
/*
 * Mode control logic: 24-bit serial control word on its own clock, mode pins,
 * failure sequencing and the resulting output drive states.
 * Assumes mode pins and fault levels are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
// What this block does
// - Control word is 24 bits, loaded serially.
// - Shifting only while serial enable low.
// - Each rising serial clock edge shifts data in.
// - Reset input clears whole control word.
// - Modes combine by fixed priority, outputs registered.
// - Brake pin only; park both; sleep serial.
// - Spindle off floats all, disables amplifier.
// - Actuator off floats actuator, park works.
// - Both off bits give sleep mode.
// - Park when bit or pin requests.
// - Park: negative at park level, positive zero.
// - Brake pin low drives phases low.
// - Stiction clock steps phases while enabled.
// - Failure: flag low, park, float then brake.
// - Under-voltage flag is active low.
// - Supply drop over 1 us is failure.
module samc_mode_ctrl
	import samc_pkg::*;
#(
	parameter int BRAKE_DELAY = BRAKE_DELAY_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_serial_clk,
	input wire logic i_serial_data_in,
	input wire logic i_serial_enable_n,
	input wire logic i_word_reset,
	input wire logic i_brake_n,
	input wire logic i_park_n,
	input wire logic i_stiction_mode_en,
	input wire logic i_stiction_clock_in,
	input wire logic i_supply_low,
	input wire logic i_over_temp,
	output logic [1:0] o_phase_out_a,
	output logic [1:0] o_phase_out_b,
	output logic [1:0] o_phase_out_c,
	output logic [1:0] o_actuator_out_pos,
	output logic [1:0] o_actuator_out_neg,
	output logic o_aux_amp_en,
	output logic o_bias_en,
	output logic o_sleep,
	output logic o_park_active,
	output logic o_undervoltage_flag_n
);
	logic [WORD_W-1:0] shift_reg;
	logic [4:0] bit_cnt_reg;
	logic [WORD_W-1:0] hold_reg;
	logic hold_tgl_reg;

	// Serial domain shift. The word reset is a pin and so acts without a link edge
	// only through the system side; here it clears on the next serial edge too.
	always_ff @(posedge i_serial_clk) begin
		if (i_word_reset) begin
			shift_reg <= WORD_RESET;
			bit_cnt_reg <= 5'h0;
		end else if (!i_serial_enable_n) begin
			shift_reg <= {shift_reg[WORD_W-2:0], i_serial_data_in};
			if (bit_cnt_reg != 5'(WORD_W))
				bit_cnt_reg <= bit_cnt_reg + 5'h1;
		end else begin
			bit_cnt_reg <= 5'h0;
		end
	end

	// Capture a finished word on the first serial edge after enable rises; the
	// toggle then tells the system side the held word is stable.
	always_ff @(posedge i_serial_clk) begin
		if (i_word_reset) begin
			hold_reg <= WORD_RESET;
			hold_tgl_reg <= 1'b0;
		end else if (i_serial_enable_n && bit_cnt_reg == 5'(WORD_W)) begin
			hold_reg <= shift_reg;
			hold_tgl_reg <= ~hold_tgl_reg;
		end
	end

	// Toggle crossing into the system clock.
	logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= hold_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
		end
	end

	// Pin synchronisers for all asynchronous level inputs.
	logic [6:0] pin_s1_reg, pin_s2_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// Reset to each pin's idle level, so that no false stiction edge,
			// word clear or failure appears in the first cycles after reset.
			pin_s1_reg <= 7'h30;
			pin_s2_reg <= 7'h30;
		end else begin
			pin_s1_reg <= {i_word_reset, i_brake_n, i_park_n, i_stiction_mode_en,
				i_stiction_clock_in, i_supply_low, i_over_temp};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire logic word_clr = pin_s2_reg[6];
	wire logic brake_n = pin_s2_reg[5];
	wire logic park_n = pin_s2_reg[4];
	wire logic stic_en = pin_s2_reg[3];
	wire logic stic_clk = pin_s2_reg[2];
	wire logic supply_low = pin_s2_reg[1];
	wire logic over_temp = pin_s2_reg[0];

	// Mode bits: cleared by the reset pin, else loaded on each finished word.
	logic spindle_off_reg, actuator_off_reg, park_bit_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst || word_clr) begin
			spindle_off_reg <= 1'b0;
			actuator_off_reg <= 1'b0;
			park_bit_reg <= 1'b0;
		end else if (tgl_s2_reg != tgl_s3_reg) begin
			spindle_off_reg <= hold_reg[BIT_SPINDLE_OFF];
			actuator_off_reg <= hold_reg[BIT_ACTUATOR_OFF];
			park_bit_reg <= hold_reg[BIT_PARK];
		end
	end

	// Supply fault filter: only a drop longer than the limit counts.
	logic [7:0] low_cnt_reg;
	logic supply_fault_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst || !supply_low) begin
			low_cnt_reg <= 8'h0;
			supply_fault_reg <= 1'b0;
		end else if (low_cnt_reg == 8'(SUPPLY_FAULT_CYC)) begin
			supply_fault_reg <= 1'b1;
		end else begin
			low_cnt_reg <= low_cnt_reg + 8'h1;
		end
	end

	// Failure sequence: float the phases while parking, then brake low side.
	samc_fail_t fail_state_reg;
	logic [31:0] fail_cnt_reg;
	wire logic failure = supply_fault_reg || over_temp;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fail_state_reg <= SAMC_RUN;
			fail_cnt_reg <= 32'h0;
		end else begin
			unique case (fail_state_reg)
				SAMC_RUN: begin
					fail_cnt_reg <= 32'h0;
					if (failure)
						fail_state_reg <= SAMC_FAIL_FLOAT;
				end
				SAMC_FAIL_FLOAT: begin
					if (!failure)
						fail_state_reg <= SAMC_RUN;
					else if (fail_cnt_reg == 32'(BRAKE_DELAY - 1))
						fail_state_reg <= SAMC_FAIL_BRAKE;
					else
						fail_cnt_reg <= fail_cnt_reg + 32'h1;
				end
				SAMC_FAIL_BRAKE: begin
					if (!failure)
						fail_state_reg <= SAMC_RUN;
				end
			endcase
		end
	end

	// Stiction stepping: each rising stiction clock advances a one-hot phase.
	logic stic_clk_d_reg;
	logic [2:0] step_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stic_clk_d_reg <= 1'b0;
			step_reg <= PHASE_STEP0;
		end else begin
			stic_clk_d_reg <= stic_clk;
			if (!stic_en)
				step_reg <= PHASE_STEP0;
			else if (stic_clk && !stic_clk_d_reg)
				step_reg <= {step_reg[1:0], step_reg[2]};
		end
	end

	// Output decode. Modes combine by priority: on the phases ground wins over float,
	// float over stiction; on the actuator spindle off (no failure) over park over actuator off.
	wire logic fail_any = fail_state_reg != SAMC_RUN;
	wire logic park = park_bit_reg || !park_n || fail_any;
	samc_drive_t ph_next [3];
	samc_drive_t pos_next, neg_next;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (fail_state_reg == SAMC_FAIL_BRAKE || !brake_n)
				ph_next[i] = SAMC_LOW;
			else if (spindle_off_reg || fail_state_reg == SAMC_FAIL_FLOAT)
				ph_next[i] = SAMC_FLOAT;
			else if (stic_en)
				ph_next[i] = step_reg[i] ? SAMC_HIGH : SAMC_FLOAT;
			else
				ph_next[i] = SAMC_HIGH;
		end
		if (spindle_off_reg && !fail_any) begin
			pos_next = SAMC_FLOAT;
			neg_next = SAMC_FLOAT;
		end else if (park) begin
			pos_next = SAMC_LOW;
			neg_next = SAMC_HIGH;
		end else if (actuator_off_reg) begin
			pos_next = SAMC_FLOAT;
			neg_next = SAMC_FLOAT;
		end else begin
			pos_next = SAMC_HIGH;
			neg_next = SAMC_HIGH;
		end
	end

	// All outputs are registered, one cycle after the mode changes.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_phase_out_a <= SAMC_FLOAT;
			o_phase_out_b <= SAMC_FLOAT;
			o_phase_out_c <= SAMC_FLOAT;
			o_actuator_out_pos <= SAMC_FLOAT;
			o_actuator_out_neg <= SAMC_FLOAT;
			o_aux_amp_en <= 1'b0;
			o_bias_en <= 1'b0;
			o_sleep <= 1'b0;
			o_park_active <= 1'b0;
			o_undervoltage_flag_n <= 1'b1;
		end else begin
			o_phase_out_a <= ph_next[0];
			o_phase_out_b <= ph_next[1];
			o_phase_out_c <= ph_next[2];
			o_actuator_out_pos <= pos_next;
			o_actuator_out_neg <= neg_next;
			o_aux_amp_en <= !spindle_off_reg;
			o_bias_en <= !spindle_off_reg;
			o_sleep <= spindle_off_reg && actuator_off_reg;
			o_park_active <= park;
			o_undervoltage_flag_n <= !failure;
		end
	end

	chk_brake_low: assert property (@(posedge i_clk) disable iff (i_rst)
		!brake_n |=> o_phase_out_a == SAMC_LOW && o_phase_out_c == SAMC_LOW)
		else $error("Brake did not ground phases.");
	chk_park_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		(park && !spindle_off_reg) |=> o_actuator_out_neg == SAMC_HIGH
			&& o_actuator_out_pos == SAMC_LOW)
		else $error("Park drive wrong.");
	chk_sleep_mode: assert property (@(posedge i_clk) disable iff (i_rst)
		(spindle_off_reg && actuator_off_reg) |=> o_sleep)
		else $error("Sleep not entered.");
	chk_spindle_float: assert property (@(posedge i_clk) disable iff (i_rst)
		(spindle_off_reg && brake_n && !fail_any) |=> o_phase_out_b == SAMC_FLOAT
			&& !o_aux_amp_en)
		else $error("Spindle off not floating.");
	chk_uv_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		failure |=> !o_undervoltage_flag_n)
		else $error("Flag not low on failure.");
	chk_fault_filter: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(supply_fault_reg) |-> $past(supply_low, 50))
		else $error("Supply fault too early.");
	chk_fail_float: assert property (@(posedge i_clk) disable iff (i_rst)
		(fail_state_reg == SAMC_RUN && failure) |=> fail_state_reg == SAMC_FAIL_FLOAT)
		else $error("Failure did not float phases.");
	chk_word_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		word_clr |=> !spindle_off_reg && !actuator_off_reg && !park_bit_reg)
		else $error("Reset pin did not clear modes.");
	// The float phase of a failure lasts exactly the brake delay, then grounds.
	chk_brake_delay: assert property (@(posedge i_clk) disable iff (i_rst)
		(fail_state_reg == SAMC_FAIL_FLOAT && failure
			&& fail_cnt_reg == 32'(BRAKE_DELAY - 1)) |=> fail_state_reg == SAMC_FAIL_BRAKE)
		else $error("Brake did not follow the float delay.");
	chk_fail_ground: assert property (@(posedge i_clk) disable iff (i_rst)
		fail_state_reg == SAMC_FAIL_BRAKE |=> o_phase_out_b == SAMC_LOW)
		else $error("Failure brake did not ground phases.");
	// Each synchronised stiction edge must move the driven phase on.
	chk_stic_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(stic_en && stic_clk && !stic_clk_d_reg) |=> step_reg != $past(step_reg))
		else $error("Stiction edge did not step phases.");
	cov_sleep: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_sleep));
	cov_fail_brake: cover property (@(posedge i_clk) disable iff (i_rst)
		fail_state_reg == SAMC_FAIL_BRAKE);
	cov_park_pin: cover property (@(posedge i_clk) disable iff (i_rst) !park_n);
	cov_stic_step: cover property (@(posedge i_clk) disable iff (i_rst)
		stic_en && stic_clk && !stic_clk_d_reg);
	cov_word_load: cover property (@(posedge i_clk) disable iff (i_rst)
		tgl_s2_reg != tgl_s3_reg);
endmodule : samc_mode_ctrl

// [tb/samc_host_model.sv]
/*
 * Host model: drives the serial port of the mode control block.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/10ps
module samc_host_model (
	output logic o_sclk,
	output logic o_data,
	output logic o_enable_n,
	output logic o_word_reset
);
	// Idle levels at time zero.
	initial begin
		o_sclk = 1'b0;
		o_data = 1'b0;
		o_enable_n = 1'b1;
		o_word_reset = 1'b0;
	end
	// One 160 ns serial period; the clock stands still between frames.
	task automatic tick();
		#80 o_sclk = 1'b1;
		#80 o_sclk = 1'b0;
	endtask : tick
	// Sends the top n bits of w, first bit first, then commits with one edge.
	task automatic send(input logic [23:0] w, input int n);
		o_enable_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_data = w[23 - i];
			tick();
		end
		o_enable_n = 1'b1;
		o_data = ~o_data; // A released line must not look held.
		tick();
	endtask : send
	// Clears the word; the reset must span a serial edge.
	task automatic clear();
		o_word_reset = 1'b1;
		tick();
		o_word_reset = 1'b0;
	endtask : clear
endmodule : samc_host_model

// [tb/spindle_actuator_mode_control_tb.sv]
/*
 * Self-checking bench for the mode control block.
 * Assumes the host model in its own file drives the serial port.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module spindle_actuator_mode_control_tb;
	import samc_pkg::*;
	localparam int BD = 10;
	logic i_clk, i_rst, sclk, sdat, sen_n, wrst;
	logic brk_n = 1'b1, prk_n = 1'b1, sme = 1'b0, stc = 1'b0, sup = 1'b0, ot = 1'b0;
	logic [1:0] pa, pb, pc, ap, an;
	logic aux, bias, slp, park, flag_n;
	int n_mismatch = 0;
	int n_compared = 0;
	samc_mode_ctrl #(.BRAKE_DELAY(BD)) i_samc_mode_ctrl (.i_clk(i_clk), .i_rst(i_rst),
		.i_serial_clk(sclk), .i_serial_data_in(sdat), .i_serial_enable_n(sen_n),
		.i_word_reset(wrst), .i_brake_n(brk_n), .i_park_n(prk_n),
		.i_stiction_mode_en(sme), .i_stiction_clock_in(stc), .i_supply_low(sup),
		.i_over_temp(ot), .o_phase_out_a(pa), .o_phase_out_b(pb), .o_phase_out_c(pc),
		.o_actuator_out_pos(ap), .o_actuator_out_neg(an), .o_aux_amp_en(aux),
		.o_bias_en(bias), .o_sleep(slp), .o_park_active(park),
		.o_undervoltage_flag_n(flag_n));
	samc_host_model i_samc_host_model (.o_sclk(sclk), .o_data(sdat),
		.o_enable_n(sen_n), .o_word_reset(wrst));
	// System clock; the serial clock runs from the host model unrelated to it.
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask : cyc
	task automatic load(input logic [23:0] w);
		i_samc_host_model.send(w, 24);
		cyc(10);
	endtask : load
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// Each serial-selected mode with its documented output states.
	task automatic t_modes();
		load(24'h80_0000);
		`CHK("pa", SAMC_FLOAT, pa)
		`CHK("ap", SAMC_FLOAT, ap)
		`CHK("aux", 1'b0, aux)
		`CHK("bias", 1'b0, bias)
		load(24'h40_0000);
		`CHK("an", SAMC_FLOAT, an)
		`CHK("aux", 1'b1, aux)
		load(24'hC0_0000);
		`CHK("sleep", 1'b1, slp)
		load(24'h60_0000);
		`CHK("an", SAMC_HIGH, an)
		load(24'h20_0000);
		`CHK("park", 1'b1, park)
		`CHK("ap", SAMC_LOW, ap)
		`CHK("sleep", 1'b0, slp)
		$display("done modes");
	endtask : t_modes
	// A short frame is dropped and the word reset clears the modes.
	task automatic t_word();
		i_samc_host_model.send(24'h00_0000, 23);
		cyc(10);
		`CHK("park", 1'b1, park)
		load(24'hC0_0000);
		`CHK("sleep", 1'b1, slp)
		i_samc_host_model.clear();
		cyc(10);
		`CHK("sleep", 1'b0, slp)
		$display("done word");
	endtask : t_word
	// Park and brake pins.
	task automatic t_pins();
		logic [1:0] a0;
		a0 = ap;
		prk_n = 1'b0;
		cyc(5);
		`CHK("park", 1'b1, park)
		`CHK("an", SAMC_HIGH, an)
		prk_n = 1'b1;
		brk_n = 1'b0;
		cyc(5);
		`CHK("pabc", {3{SAMC_LOW}}, {pa, pb, pc})
		`CHK("ap", a0, ap)
		brk_n = 1'b1;
		$display("done pins");
	endtask : t_pins
	// A burst of 18 stiction pulses steps one driven phase each time.
	task automatic t_stiction();
		logic [5:0] prev;
		sme = 1'b1;
		cyc(5);
		prev = {pa, pb, pc};
		for (int i = 0; i < 18; i++) begin
			stc = 1'b1;
			cyc(3);
			stc = 1'b0;
			cyc(3);
			`CHK("hi", 2, (pa == SAMC_HIGH) + (pb == SAMC_HIGH) + (pc == SAMC_HIGH) + 1)
			`CHK("step", 1'b1, {pa, pb, pc} !== prev)
			prev = {pa, pb, pc};
		end
		sme = 1'b0;
		$display("done stiction");
	endtask : t_stiction
	// Supply glitch, real supply fault, then over-temperature.
	task automatic t_fault();
		sup = 1'b1;
		cyc(30);
		sup = 1'b0;
		cyc(5);
		`CHK("flag", 1'b1, flag_n)
		sup = 1'b1;
		cyc(56);
		`CHK("flag", 1'b0, flag_n)
		`CHK("pa", SAMC_FLOAT, pa)
		`CHK("an", SAMC_HIGH, an)
		cyc(BD + 5);
		`CHK("pa", SAMC_LOW, pa)
		sup = 1'b0;
		i_rst = 1'b1;
		cyc(2);
		i_rst = 1'b0;
		ot = 1'b1;
		cyc(6);
		`CHK("flag", 1'b0, flag_n)
		ot = 1'b0;
		$display("done fault");
	endtask : t_fault
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		summarize();
	end
	// Main sequence.
	initial begin
		i_rst = 1'b1;
		cyc(1);
		// The serial side has no system reset, so clear it while reset holds.
		i_samc_host_model.clear();
		cyc(20);
		i_rst = 1'b0;
		cyc(3);
		`CHK("flag", 1'b1, flag_n)
		`CHK("sleep", 1'b0, slp)
		t_modes();
		t_word();
		t_pins();
		t_stiction();
		t_fault();
		summarize();
	end
endmodule : spindle_actuator_mode_control_tb
